// >>> hss_regs.svh
// Register offsets, field positions and reset values of the slot/status bank
`ifndef HSS_REGS_SVH
`define HSS_REGS_SVH

// Command byte layout
`define HSS_CMD_RW_BIT 7
`define HSS_CMD_ADDR_MSB 6

// Register addresses (read form; write form has the read/write bit set)
`define HSS_ADDR_TX_SLOT 7'h00
`define HSS_ADDR_RX_SLOT 7'h01
`define HSS_ADDR_LOOP 7'h02
`define HSS_ADDR_STATUS 7'h39

// Slot registers
`define HSS_HWY_BIT 7
`define HSS_SLOT_MSB 6

// Loopback register fields
`define HSS_LB_DIG_2M 6
`define HSS_LB_DIG_PCM 5
`define HSS_LB_ANA_1MDC 3
`define HSS_LB_ANA_2M 2
`define HSS_LB_ANA_PCM 1
`define HSS_LB_RX_BLOCK 0
`define HSS_LB_WMASK 8'h6F
`define HSS_LB_RESET 8'h00

// Highway select reset value and blank read value
`define HSS_HWY_RESET 1'b0
`define HSS_BYTE_ZERO 8'h00

`endif

// >>> hss_pkg.sv
// Types shared by the slot/status register bank
package hss_pkg;

  typedef logic [7:0] hss_byte_t;
  typedef logic [6:0] hss_slot_t;

  // Host interface mode of the control port
  typedef enum logic {
    HSS_MODE_MICRO_HOST_PORT,
    HSS_MODE_GCI
  } hss_mode_t;

endpackage : hss_pkg

// >>> hss_slot_status_regs.sv
// Slot, highway, loopback and line status register bank, four channels
//
// Summary of operation
// R1: Status reads at 39H with read/write bit clear; writes at B9H with it set.
// R2: Micro host port status read gives hook at bit 2n, ground-current 2n+1.
// R3: Hook bit reads 1 off-hook, 0 on-hook; resets to 0.
// R4: Ground-current bit reads 1 on longitudinal current; resets to 0.
// R5: Micro host port status read clears pending hook/ground-current interrupt.
// R6: In GCI mode line status goes only via upstream C/I channel.
// R7: In GCI mode status reads always return 00H.
// R8: In GCI mode a status read still clears detection interrupt.
// R9: Any write to status address clears all pending interrupts.
// R10: Tx slot register 00H/80H; bit 7 selects tx highway one or two.
// R11: Seven-bit tx slot field 0..127 picks the transmit time slot.
// R12: Tx slot field resets to channel index, 00H through 03H.
// R13: Slot and highway registers act only in micro host port mode.
// R14: Rx slot register 01H/81H; bit 7 selects rx highway one or two.
// R15: Seven-bit rx slot field 0..127 picks the receive time slot.
// R16: Rx slot field resets to channel index, 00H through 03H.
// R17: PCM-side loopbacks in register 02H/82H act only in micro host port mode.
// R18: Bit 0 of loopback register blocks receive path when 1; default 0.
// R19: Loop bits 6,5,3,2,1 close when 1, reset 0; bits 7,4 reserved.
// R20: Polarity select 0 makes interrupt active low, 1 active high.
`timescale 1ns/1ps
`include "hss_regs.svh"

module hss_slot_status_regs #(
  parameter int NUM_CH = 4
) (
  clock,
  reset_n,
  clkEn,
  ifMode,
  cmdValid,
  cmdByte,
  cmdChan,
  wrData,
  rdData,
  rdValid,
  hookState,
  groundCurrentState,
  detEvent,
  irqPolaritySel,
  detIrqPending,
  irqOut,
  clearAllIrq,
  txHighwaySel,
  txSlotNum,
  rxHighwaySel,
  rxSlotNum,
  digLoopVia2m,
  digLoopPcmSide,
  anaLoop1mDc,
  anaLoopVia2m,
  anaLoopPcmSide,
  rxPathBlock
);
  import hss_pkg::*;

  input wire logic clock;
  input wire logic reset_n;
  input wire logic clkEn;
  input wire hss_pkg::hss_mode_t ifMode;
  input wire logic cmdValid;
  input wire hss_pkg::hss_byte_t cmdByte;
  input wire logic [1:0] cmdChan;
  input wire hss_pkg::hss_byte_t wrData;
  output logic [7:0] rdData;
  output logic rdValid;
  input wire logic [NUM_CH-1:0] hookState;
  input wire logic [NUM_CH-1:0] groundCurrentState;
  input wire logic detEvent;
  input wire logic irqPolaritySel;
  output logic detIrqPending;
  output logic irqOut;
  output logic clearAllIrq;
  output logic [NUM_CH-1:0] txHighwaySel;
  output logic [7*NUM_CH-1:0] txSlotNum;
  output logic [NUM_CH-1:0] rxHighwaySel;
  output logic [7*NUM_CH-1:0] rxSlotNum;
  output logic [NUM_CH-1:0] digLoopVia2m;
  output logic [NUM_CH-1:0] digLoopPcmSide;
  output logic [NUM_CH-1:0] anaLoop1mDc;
  output logic [NUM_CH-1:0] anaLoopVia2m;
  output logic [NUM_CH-1:0] anaLoopPcmSide;
  output logic [NUM_CH-1:0] rxPathBlock;

  // Status byte holds two bits per channel, so only four channels fit
  if (NUM_CH != 4) begin : gBadChCount
    $error("hss_slot_status_regs: NUM_CH must be 4");
  end

  //--------------------------------------------------------------------
  // Command decode
  //--------------------------------------------------------------------

  logic isWrite;
  logic [6:0] cmdAddr;
  logic hitStatus;
  logic hitTx;
  logic hitRx;
  logic hitLoop;
  logic statusRead;
  logic statusWrite;
  logic microMode;

  // Address and direction come straight from the command byte
  assign isWrite = cmdByte[`HSS_CMD_RW_BIT];
  assign cmdAddr = cmdByte[`HSS_CMD_ADDR_MSB:0];
  assign hitStatus = cmdValid && (cmdAddr == `HSS_ADDR_STATUS); // R1
  assign hitTx = cmdValid && (cmdAddr == `HSS_ADDR_TX_SLOT);
  assign hitRx = cmdValid && (cmdAddr == `HSS_ADDR_RX_SLOT);
  assign hitLoop = cmdValid && (cmdAddr == `HSS_ADDR_LOOP);
  assign statusRead = hitStatus && !isWrite; // R1
  assign statusWrite = hitStatus && isWrite; // R1
  assign microMode = (ifMode == HSS_MODE_MICRO_HOST_PORT);

  //--------------------------------------------------------------------
  // Per-channel storage
  //--------------------------------------------------------------------

  hss_byte_t txReg_q [NUM_CH];
  hss_byte_t rxReg_q [NUM_CH];
  hss_byte_t loopReg_q [NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : gChan
      logic sel;
      assign sel = (cmdChan == 2'(ch)) && isWrite;

      // Slot registers reset to the channel's own index
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          txReg_q[ch] <= {`HSS_HWY_RESET, 7'(ch)}; // R12
          rxReg_q[ch] <= {`HSS_HWY_RESET, 7'(ch)}; // R16
        end else if (clkEn) begin
          if (hitTx && sel) begin
            txReg_q[ch] <= wrData; // R10 R11
          end
          if (hitRx && sel) begin
            rxReg_q[ch] <= wrData; // R14 R15
          end
        end
      end

      // Reserved loopback bits are never stored and read back as zero
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          loopReg_q[ch] <= `HSS_LB_RESET; // R19
        end else if (clkEn && hitLoop && sel) begin
          loopReg_q[ch] <= wrData & `HSS_LB_WMASK; // R19
        end
      end

      // Effective controls; slot and PCM-side loops idle in GCI mode
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          txHighwaySel[ch] <= `HSS_HWY_RESET;
          txSlotNum[7*ch +: 7] <= 7'(ch);
          rxHighwaySel[ch] <= `HSS_HWY_RESET;
          rxSlotNum[7*ch +: 7] <= 7'(ch);
          digLoopVia2m[ch] <= 1'b0;
          digLoopPcmSide[ch] <= 1'b0;
          anaLoop1mDc[ch] <= 1'b0;
          anaLoopVia2m[ch] <= 1'b0;
          anaLoopPcmSide[ch] <= 1'b0;
          rxPathBlock[ch] <= 1'b0;
        end else if (clkEn) begin
          if (microMode) begin
            txHighwaySel[ch] <= txReg_q[ch][`HSS_HWY_BIT]; // R13 R10
            txSlotNum[7*ch +: 7] <= txReg_q[ch][`HSS_SLOT_MSB:0]; // R11
            rxHighwaySel[ch] <= rxReg_q[ch][`HSS_HWY_BIT]; // R13 R14
            rxSlotNum[7*ch +: 7] <= rxReg_q[ch][`HSS_SLOT_MSB:0]; // R15
          end else begin
            txHighwaySel[ch] <= `HSS_HWY_RESET; // R13
            txSlotNum[7*ch +: 7] <= 7'(ch);
            rxHighwaySel[ch] <= `HSS_HWY_RESET;
            rxSlotNum[7*ch +: 7] <= 7'(ch);
          end
          digLoopVia2m[ch] <= loopReg_q[ch][`HSS_LB_DIG_2M]; // R19
          digLoopPcmSide[ch] <= microMode &&
            loopReg_q[ch][`HSS_LB_DIG_PCM]; // R17
          anaLoop1mDc[ch] <= loopReg_q[ch][`HSS_LB_ANA_1MDC]; // R19
          anaLoopVia2m[ch] <= loopReg_q[ch][`HSS_LB_ANA_2M]; // R19
          anaLoopPcmSide[ch] <= microMode &&
            loopReg_q[ch][`HSS_LB_ANA_PCM]; // R17
          rxPathBlock[ch] <= loopReg_q[ch][`HSS_LB_RX_BLOCK]; // R18
        end
      end
    end
  endgenerate

  //--------------------------------------------------------------------
  // Line status byte
  //--------------------------------------------------------------------

  hss_byte_t statusByte;
  integer i;

  // Interleave hook and ground-current bits, two per channel
  always_comb begin
    statusByte = `HSS_BYTE_ZERO;
    for (i = 0; i < NUM_CH; i++) begin
      statusByte[2*i] = hookState[i]; // R2 R3
      statusByte[2*i+1] = groundCurrentState[i]; // R2 R4
    end
  end

  //--------------------------------------------------------------------
  // Read path
  //--------------------------------------------------------------------

  hss_byte_t rdMux;

  // Unmapped addresses read as zero rather than stale data
  always_comb begin
    rdMux = `HSS_BYTE_ZERO;
    if (hitStatus) begin
      rdMux = microMode ? statusByte : `HSS_BYTE_ZERO; // R6 R7
    end else if (hitTx) begin
      rdMux = txReg_q[cmdChan];
    end else if (hitRx) begin
      rdMux = rxReg_q[cmdChan];
    end else if (hitLoop) begin
      rdMux = loopReg_q[cmdChan];
    end
  end

  // Read answer one cycle after the command, held until the next read
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= `HSS_BYTE_ZERO;
      rdValid <= 1'b0;
    end else if (clkEn) begin
      rdValid <= cmdValid && !isWrite;
      if (cmdValid && !isWrite) begin
        rdData <= rdMux;
      end
    end
  end

  //--------------------------------------------------------------------
  // Detection interrupt and clears
  //--------------------------------------------------------------------

  // A detection event in the clearing cycle wins, so no event is lost
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      detIrqPending <= 1'b0;
    end else if (clkEn) begin
      if (detEvent) begin
        detIrqPending <= 1'b1;
      end else if (statusRead || statusWrite) begin
        detIrqPending <= 1'b0; // R5 R8 R9
      end
    end
  end

  // Other interrupt sources outside this bank listen to this pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      clearAllIrq <= 1'b0;
    end else if (clkEn) begin
      clearAllIrq <= statusWrite; // R9
    end
  end

  // Pin level follows the polarity select; low-active while the select is 0
  assign irqOut = irqPolaritySel ? detIrqPending : !detIrqPending; // R20

endmodule : hss_slot_status_regs

// >>> hss_host_model.sv
// Host processor model driving the command port of the register bank
`timescale 1ns/1ps
module hss_host_model (
  input wire logic clock,
  output hss_pkg::hss_byte_t cmdByte,
  output logic cmdValid,
  output logic [1:0] cmdChan,
  output hss_pkg::hss_byte_t wrData,
  input wire logic [7:0] rdData,
  input wire logic rdValid
);
  import hss_pkg::*;
  logic gotValid;
  // Idle port at time zero
  initial begin
    cmdValid = 1'b0;
    cmdByte = 8'h00;
    cmdChan = 2'h0;
    wrData = 8'h00;
  end
  // One command byte; fields are inverted once taken so nothing stale shows
  task automatic xfer(input hss_byte_t c, input logic [1:0] ch,
    input hss_byte_t dat, output logic [7:0] rd);
    @(posedge clock);
    #1;
    cmdValid = 1'b1;
    cmdByte = c;
    cmdChan = ch;
    wrData = dat;
    @(posedge clock);
    #1;
    rd = rdData;
    gotValid = rdValid;
    cmdValid = 1'b0;
    cmdByte = ~c;
    cmdChan = ~ch;
    wrData = ~dat;
  endtask : xfer
endmodule : hss_host_model

// >>> hss_slot_status_regs_sva.sv
// Command, status and interrupt checks for the slot/status register bank
`timescale 1ns/1ps
module hss_slot_status_regs_sva #(
  parameter int NUM_CH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire hss_pkg::hss_mode_t ifMode,
  input wire logic cmdValid,
  input wire hss_pkg::hss_byte_t cmdByte,
  input wire logic [7:0] rdData,
  input wire logic rdValid,
  input wire logic [NUM_CH-1:0] hookState,
  input wire logic [NUM_CH-1:0] groundCurrentState,
  input wire logic detEvent,
  input wire logic irqPolaritySel,
  input wire logic detIrqPending,
  input wire logic irqOut,
  input wire logic clearAllIrq
);
  import hss_pkg::*;
  logic take;
  logic [7:0] lineStat;
  // Taken command; status byte interleaves hook and ground per channel
  assign take = cmdValid && clkEn;
  always_comb begin
    for (int i = 0; i < 4; i++) lineStat[2*i+:2] = {groundCurrentState[i],
      hookState[i]};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (take && !cmdByte[7] |=> rdValid)
    else $error("read gave no answer");
  // A frozen enable holds the last answer, so only fresh cycles count
  rd_cause_a: assert property (rdValid && $past(clkEn) |->
    $past(take && !cmdByte[7]))
    else $error("answer without read");
  stat_mpi_a: assert property (take && cmdByte == 8'h39 &&
    ifMode == HSS_MODE_MICRO_HOST_PORT |=> rdData == $past(lineStat))
    else $error("status byte wrong");
  stat_gci_a: assert property (take && cmdByte == 8'h39 &&
    ifMode == HSS_MODE_GCI |=> rdData == 8'h00)
    else $error("status not blank");
  rd_clear_a: assert property (take && cmdByte == 8'h39 &&
    !detEvent |=> !detIrqPending)
    else $error("status read kept pending");
  wr_clear_a: assert property (take && cmdByte == 8'hB9 &&
    !detEvent |=> clearAllIrq && !detIrqPending)
    else $error("write did not clear");
  clr_cause_a: assert property (clearAllIrq && $past(clkEn) |->
    $past(take && cmdByte == 8'hB9))
    else $error("stray clear pulse");
  irq_pol_a: assert property (irqOut ==
    (irqPolaritySel ? detIrqPending : !detIrqPending))
    else $error("interrupt polarity wrong");
  det_set_a: assert property (detEvent && clkEn |=> detIrqPending)
    else $error("event not latched");
  freeze_hold_a: assert property (!clkEn |=> $stable(rdData) &&
    $stable({rdValid, detIrqPending, clearAllIrq}))
    else $error("state moved while frozen");
endmodule : hss_slot_status_regs_sva
bind hss_slot_status_regs hss_slot_status_regs_sva #(.NUM_CH(NUM_CH)) sva (.*);

// >>> tb_hss_slot_status_regs.sv
// Self-checking bench for the slot/status register bank
`timescale 1ns/1ps
`include "hss_regs.svh"
module tb_hss_slot_status_regs;
  import hss_pkg::*;
  logic clock, reset_n, clkEn, cmdValid, rdValid, detEvent, irqPolaritySel;
  logic detIrqPending, irqOut, clearAllIrq;
  hss_mode_t ifMode;
  hss_byte_t cmdByte, wrData;
  logic [1:0] cmdChan, k;
  logic [7:0] rdData, rd, d, e;
  logic [3:0] hookState, groundCurrentState, txHighwaySel, rxHighwaySel;
  logic [3:0] digLoopVia2m, digLoopPcmSide, anaLoop1mDc, anaLoopVia2m;
  logic [3:0] anaLoopPcmSide, rxPathBlock;
  logic [27:0] txSlotNum, rxSlotNum;
  logic [15:0] rnd;
  int err_count, total_checks;
  localparam logic [27:0] SlotRst = {7'h03, 7'h02, 7'h01, 7'h00};
  hss_slot_status_regs DUT (.*);
  hss_host_model host (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] stat(input logic [3:0] h, g);
    for (int i = 0; i < 4; i++) stat[2*i+:2] = {g[i], h[i]};
  endfunction : stat
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One detection event; pending must latch it
  task automatic pulse;
    @(posedge clock);
    #1;
    detEvent = 1'b1;
    @(posedge clock);
    #1;
    detEvent = 1'b0;
    chk(detIrqPending, 1'b1);
  endtask : pulse
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog; the whole run is a few hundred cycles
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    {clkEn, detEvent, irqPolaritySel, hookState, groundCurrentState} = '0;
    ifMode = HSS_MODE_MICRO_HOST_PORT;
    reset_n = 1'b0;
    rnd = 16'h4BC3;
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1'b1;
    clkEn = 1'b1;
    chk({txSlotNum, rxSlotNum} === {SlotRst, SlotRst}, 1'b1);
    chk({txHighwaySel, rxHighwaySel, rxPathBlock}, 28'h0);
    chk({digLoopVia2m, digLoopPcmSide, anaLoop1mDc}, 28'h0);
    chk({anaLoopVia2m, anaLoopPcmSide, irqOut}, 28'h1);
    for (int j = 0; j < 4; j++) begin
      host.xfer(8'h00, 2'(j), 8'h00, rd);
      chk(rd, 28'(j));
      chk(host.gotValid, 1'b1);
      host.xfer(8'h01, 2'(j), 8'h00, rd);
      chk(rd, 28'(j));
    end
    // Random settings per channel, with all-ones and all-zeros first
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd[7:0];
      e = ~d;
      k = rnd[9:8];
      host.xfer(8'h80, k, d, rd);
      host.xfer(8'h81, k, e, rd);
      host.xfer(8'h82, k, d, rd);
      @(posedge clock);
      #1;
      chk({txHighwaySel[k], txSlotNum[7*k+:7]}, d);
      chk({rxHighwaySel[k], rxSlotNum[7*k+:7]}, e);
      chk({digLoopVia2m[k], digLoopPcmSide[k], anaLoop1mDc[k],
        anaLoopVia2m[k], anaLoopPcmSide[k]}, {d[6:5], d[3:1]});
      chk(rxPathBlock[k], d[0]);
      host.xfer(8'h02, k, 8'h00, rd);
      chk(rd, d & `HSS_LB_WMASK);
      host.xfer(8'h00, k, 8'h00, rd);
      chk(rd, d);
      hookState = rnd[13:10];
      groundCurrentState = rnd[15:12];
      host.xfer(8'h39, k, 8'h00, rd);
      chk(rd, stat(hookState, groundCurrentState));
    end
    // Detection interrupt in both modes: read clear, then write clear
    {hookState, groundCurrentState} = 8'hA5;
    for (int m = 0; m < 2; m++) begin
      ifMode = hss_mode_t'(m);
      pulse();
      chk(irqOut, 1'b0);
      if (m == 1) chk(txSlotNum | anaLoopPcmSide, SlotRst);
      if (m == 1) chk(rxSlotNum | digLoopPcmSide, SlotRst);
      if (m == 1) chk(txHighwaySel | rxHighwaySel, 28'h0);
      host.xfer(8'h39, 2'h0, 8'h00, rd);
      chk({clearAllIrq, detIrqPending}, 2'b00);
      chk(rd, m ? 28'h0 : stat(hookState, groundCurrentState));
      pulse();
      irqPolaritySel = 1'b1;
      #1;
      chk(irqOut, 1'b1);
      host.xfer(8'hB9, 2'h0, 8'hFF, rd);
      chk({clearAllIrq, detIrqPending}, 2'b10);
      chk(host.gotValid, 1'b0);
      irqPolaritySel = 1'b0;
    end
    // Frozen enable: a clear command must not reach the pending flag
    ifMode = HSS_MODE_MICRO_HOST_PORT;
    pulse();
    clkEn = 1'b0;
    host.xfer(8'hB9, 2'h2, 8'hFF, rd);
    chk(detIrqPending, 1'b1);
    // Mid-run reset restores slot defaults over the random settings
    reset_n = 1'b0;
    @(posedge clock);
    #1;
    reset_n = 1'b1;
    chk({txSlotNum, rxSlotNum} === {SlotRst, SlotRst}, 1'b1);
    host.xfer(8'h80, 2'h2, 8'hFF, rd);
    clkEn = 1'b1;
    host.xfer(8'h00, 2'h2, 8'h00, rd);
    chk(rd, 28'h2);
    stop_test();
  end
endmodule : tb_hss_slot_status_regs
